// file: design/anpr_consts.svh
// Constants for the next-page register bank
`ifndef ANPR_CONSTS_SVH
`define ANPR_CONSTS_SVH

// Direct register addresses
`define ANPR_ADDR_CTRL 8'h6E
`define ANPR_ADDR_OFFS 8'h6F
`define ANPR_ADDR_DATA 8'hA0

// Control register fields
`define ANPR_TABLE_HI 7
`define ANPR_TABLE_LO 5
`define ANPR_PORT_HI 3
`define ANPR_PORT_LO 0
`define ANPR_TABLE_EEE 3'h1
`define ANPR_PORT_MIN 4'h1
`define ANPR_PORT_MAX 4'h3
`define ANPR_CTRL_RMASK 8'hEF

// Indirect byte offsets
`define ANPR_OFF_TX_HI 8'h0E
`define ANPR_OFF_TX_LO 8'h0F
`define ANPR_OFF_RX_HI 8'h10
`define ANPR_OFF_RX_LO 8'h11

// Transmit word reset and writable bits
`define ANPR_TX_RESET 16'h2001
`define ANPR_TX_WMASK 16'hB7FF

// Receive page reset and comparison mask
`define ANPR_RX_RESET 16'h0000
`define ANPR_ACK_IGNORE 16'hBFFF

// Consistent bursts needed, minus one
`define ANPR_CONSIST_LAST 2'h2

`endif

// file: design/anpr_pkg.sv
// Types for the next-page register bank
package anpr_pkg;

  typedef struct packed {
    logic more_pages_flag;
    logic ack;
    logic message_kind_flag;
    logic can_comply_flag;
    logic toggle;
    logic [10:0] code;
  } anpr_page_t;

  typedef struct packed {
    logic valid;
    anpr_page_t word;
  } anpr_flp_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } anpr_reg_req_t;

endpackage : anpr_pkg

// file: design/anpr_rx_check.sv
// Partner next-page acceptance for one port
`timescale 1ns/10ps
`include "anpr_consts.svh"

module anpr_rx_check (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic partner_base_toggle,
  input wire anpr_pkg::anpr_flp_t flp,
  output anpr_pkg::anpr_page_t page,
  output logic accepted
);

  logic [15:0] last_word;
  logic [1:0] match_cnt;
  logic expect_toggle;

  wire [15:0] cand = flp.word & `ANPR_ACK_IGNORE;
  wire toggle_ok = flp.word.toggle == expect_toggle;
  wire same = (cand == last_word) && (match_cnt != 2'h0);
  wire done = flp.valid && toggle_ok && same &&
              (match_cnt == `ANPR_CONSIST_LAST);
  wire [1:0] next_cnt = !toggle_ok ? 2'h0 :
                        same ? match_cnt + 2'h1 : 2'h1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_word <= 16'h0000;
      match_cnt <= 2'h0;
      expect_toggle <= 1'b0;
    end else if (start) begin
      last_word <= 16'h0000;
      match_cnt <= 2'h0;
      expect_toggle <= ~partner_base_toggle;
    end else if (done) begin
      match_cnt <= 2'h0;
      expect_toggle <= ~expect_toggle;
    end else if (flp.valid) begin
      last_word <= cand;
      match_cnt <= next_cnt;
    end
  end

  // Whole page latched at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page <= `ANPR_RX_RESET;
      accepted <= 1'b0;
    end else begin
      accepted <= done && !start;
      if (done && !start) begin
        page <= flp.word;
      end
    end
  end

endmodule : anpr_rx_check

// file: design/anpr_regs.sv
// Indirect next-page register bank for three copper ports
`timescale 1ns/10ps
`include "anpr_consts.svh"

// How it works
// - Ports 1 to 3 and a byte offset pick a byte seen at address 0xA0.
// - Transmit word bits 10:0 are a writable code field resetting to 1.
// - Received bit 15 tells whether more partner pages follow; resets 0.
// - Received bit 14 is the ack, taken after three matching bursts.
// - Received bit 13 marks a message page versus unformatted; resets 0.
// - Received bit 12 tells whether the partner can comply; resets 0.
// - Each page's toggle bit is the inverse of the previous page's.
// - The first next page's toggle is the inverse of base word bit 11.
module anpr_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire anpr_pkg::anpr_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire anpr_pkg::anpr_flp_t [2:0] flp_in,
  input wire logic [2:0] np_start,
  input wire logic [2:0] local_base_toggle,
  input wire logic [2:0] partner_base_toggle,
  input wire logic [2:0] tx_page_done,
  output anpr_pkg::anpr_page_t [2:0] tx_next_page,
  output logic [2:0] rx_page_accepted
);

  logic [2:0] table_sel;
  logic [3:0] port_sel;
  logic [7:0] offset_sel;
  logic [15:0] tx_soft [3];
  logic [2:0] tx_toggle;
  logic [15:0] tx_word [3];
  logic [15:0] rx_word [3];
  anpr_pkg::anpr_page_t rx_page [3];

  // Direct address decode
  wire ctrl_hit = reg_req.addr == `ANPR_ADDR_CTRL;
  wire offs_hit = reg_req.addr == `ANPR_ADDR_OFFS;
  wire data_hit = reg_req.addr == `ANPR_ADDR_DATA;

  // Window qualification
  wire table_ok = table_sel == `ANPR_TABLE_EEE;
  wire port_ok = (port_sel >= `ANPR_PORT_MIN) &&
                 (port_sel <= `ANPR_PORT_MAX);
  wire win_ok = table_ok && port_ok;
  wire [1:0] port_idx = port_sel[1:0] - 2'h1;
  wire win_wr = reg_req.wr && data_hit && win_ok;
  wire wr_tx_hi = win_wr && (offset_sel == `ANPR_OFF_TX_HI);
  wire wr_tx_lo = win_wr && (offset_sel == `ANPR_OFF_TX_LO);

  // Control and offset registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      table_sel <= 3'h0;
      port_sel <= 4'h0;
    end else if (reg_req.wr && ctrl_hit) begin
      table_sel <= reg_req.wdata[`ANPR_TABLE_HI:`ANPR_TABLE_LO];
      port_sel <= reg_req.wdata[`ANPR_PORT_HI:`ANPR_PORT_LO];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      offset_sel <= 8'h00;
    end else if (reg_req.wr && offs_hit) begin
      offset_sel <= reg_req.wdata;
    end
  end

  // Per-port transmit word and partner page
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_port
      wire sel_me = port_idx == 2'(gi);
      wire [15:0] hi_val = {reg_req.wdata, tx_soft[gi][7:0]};
      wire [15:0] lo_val = {tx_soft[gi][15:8], reg_req.wdata};
      wire [15:0] wr_val = wr_tx_hi ? hi_val : lo_val;
      wire do_wr = sel_me && (wr_tx_hi || wr_tx_lo);
      wire [15:0] next_soft = (wr_val & `ANPR_TX_WMASK) |
                              (tx_soft[gi] & ~`ANPR_TX_WMASK);

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          tx_soft[gi] <= `ANPR_TX_RESET;
        end else if (do_wr) begin
          tx_soft[gi] <= next_soft;
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          tx_toggle[gi] <= 1'b0;
        end else if (np_start[gi]) begin
          tx_toggle[gi] <= ~local_base_toggle[gi];
        end else if (tx_page_done[gi]) begin
          tx_toggle[gi] <= ~tx_toggle[gi];
        end
      end

      // Reserved ack bit reads zero, toggle from hardware
      assign tx_word[gi] = {tx_soft[gi][15], 1'b0, tx_soft[gi][13:12],
                            tx_toggle[gi], tx_soft[gi][10:0]};
      assign tx_next_page[gi] = tx_word[gi];

      anpr_rx_check u_rx_check (
        .clk(clk),
        .reset_n(reset_n),
        .start(np_start[gi]),
        .partner_base_toggle(partner_base_toggle[gi]),
        .flp(flp_in[gi]),
        .page(rx_page[gi]),
        .accepted(rx_page_accepted[gi])
      );

      assign rx_word[gi] = rx_page[gi];
    end
  endgenerate

  // Indirect byte selection
  wire [15:0] sel_tx = tx_word[port_idx];
  wire [15:0] sel_rx = rx_word[port_idx];
  wire [7:0] win_byte =
    (offset_sel == `ANPR_OFF_TX_HI) ? sel_tx[15:8] :
    (offset_sel == `ANPR_OFF_TX_LO) ? sel_tx[7:0] :
    (offset_sel == `ANPR_OFF_RX_HI) ? sel_rx[15:8] :
    (offset_sel == `ANPR_OFF_RX_LO) ? sel_rx[7:0] : 8'h00;
  wire [7:0] ctrl_byte = {table_sel, 1'b0, port_sel} & `ANPR_CTRL_RMASK;
  wire [7:0] next_rdata =
    ctrl_hit ? ctrl_byte :
    offs_hit ? offset_sel :
    (data_hit && win_ok) ? win_byte : 8'h00;

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule : anpr_regs

// file: sim/anpr_regs_checker.sv
// Port assertions for the next-page register bank
`timescale 1ns/10ps
module anpr_regs_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire anpr_pkg::anpr_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire anpr_pkg::anpr_flp_t [2:0] flp_in,
  input wire logic [2:0] np_start,
  input wire logic [2:0] local_base_toggle,
  input wire logic [2:0] partner_base_toggle,
  input wire logic [2:0] tx_page_done,
  input wire anpr_pkg::anpr_page_t [2:0] tx_next_page,
  input wire logic [2:0] rx_page_accepted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rd_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("stray read valid");
  a_tx_start: assert property (np_start[0] |=>
    tx_next_page[0].toggle != $past(local_base_toggle[0]))
    else $error("bad first toggle");
  a_tx_flip: assert property (tx_page_done[0] && !np_start[0] |=>
    tx_next_page[0].toggle != $past(tx_next_page[0].toggle))
    else $error("toggle not flipped");
  a_tx_hold: assert property (!np_start[0] && !tx_page_done[0] |=>
    $stable(tx_next_page[0].toggle)) else $error("toggle moved");
  a_acc_cause: assert property (rx_page_accepted[0] |->
    $past(flp_in[0].valid)) else $error("accept without burst");
  a_acc_gap: assert property (rx_page_accepted[0] |=>
    !rx_page_accepted[0] [*2]) else $error("accept too soon");
  a_acc_start: assert property (np_start[0] |=>
    !rx_page_accepted[0] [*3]) else $error("accept after start");
  c_acc: cover property (rx_page_accepted[0]);
  c_read: cover property (reg_rvalid);
  c_done: cover property (tx_page_done[0]);
endmodule : anpr_regs_checker

// file: sim/anpr_partner.sv
// Behavioural link partner sending next-page bursts
`timescale 1ns/10ps
module anpr_partner (
  input wire logic clk,
  input wire logic base_toggle,
  input wire logic start,
  output anpr_pkg::anpr_flp_t flp
);
  logic tog;
  initial flp = '0;
  always @(posedge clk) if (start) tog = ~base_toggle;
  task automatic send(input anpr_pkg::anpr_page_t w, input int n, g,
    input logic bad);
    w.toggle = tog ^ bad;
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        repeat (g) begin
          @(negedge clk);
          flp = '{1'b0, ~w};
        end
      end
      @(negedge clk);
      flp = '{1'b1, w};
      w.ack = 1'b1;
    end
    @(negedge clk);
    flp = '{1'b0, ~w};
    tog = tog ^ !bad;
  endtask : send
endmodule : anpr_partner

// file: sim/anpr_regs_tb.sv
// Self-checking bench for the next-page register bank
`timescale 1ns/10ps
module anpr_regs_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  anpr_pkg::anpr_reg_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  wire anpr_pkg::anpr_flp_t [2:0] flp;
  logic [2:0] start = '0;
  logic [2:0] lbt = '0;
  logic [2:0] pbt = '0;
  logic [2:0] done = '0;
  anpr_pkg::anpr_page_t [2:0] txp;
  logic [2:0] acc;
  int err_count = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  anpr_regs u_dut (.clk(clk), .reset_n(reset_n), .reg_req(req),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .flp_in(flp), .np_start(start),
    .local_base_toggle(lbt), .partner_base_toggle(pbt),
    .tx_page_done(done), .tx_next_page(txp), .rx_page_accepted(acc));
  anpr_partner u_lp0 (.clk(clk), .base_toggle(pbt[0]), .start(start[0]),
    .flp(flp[0]));
  anpr_partner u_lp1 (.clk(clk), .base_toggle(pbt[1]), .start(start[1]),
    .flp(flp[1]));
  anpr_partner u_lp2 (.clk(clk), .base_toggle(pbt[2]), .start(start[2]),
    .flp(flp[2]));
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic strobe(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    req = '{w, !w, a, d};
    @(negedge clk);
    req = '0;
  endtask : strobe
  task automatic rdx(input logic [7:0] a, e);
    strobe(1'b0, a, 8'h00);
    chk("rvalid", 16'h1, {15'h0, rvalid});
    chk("rdata", {8'h0, e}, {8'h0, rdata});
  endtask : rdx
  task automatic rd(input logic [3:0] p, input logic [7:0] o, e);
    strobe(1'b1, 8'h6E, {4'h2, p});
    strobe(1'b1, 8'h6F, o);
    rdx(8'hA0, e);
  endtask : rd
  task automatic pulse(input logic is_done);
    @(negedge clk);
    if (is_done) done = 3'h1;
    else start = 3'h1;
    @(negedge clk);
    done = 3'h0;
    start = 3'h0;
  endtask : pulse
  task automatic wait_acc(input logic e);
    logic hit;
    hit = acc[0];
    repeat (8) begin
      @(negedge clk);
      hit |= acc[0];
    end
    chk("accepted", {15'h0, e}, {15'h0, hit});
    if (e && !hit) end_of_test();
  endtask : wait_acc
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    for (int p = 1; p <= 3; p++) begin
      rd(p[3:0], 8'h0E, 8'h20);
      rd(p[3:0], 8'h0F, 8'h01);
      rd(p[3:0], 8'h10, 8'h00);
      rd(p[3:0], 8'h11, 8'h00);
    end
    strobe(1'b1, 8'hA0, 8'hFF);
    strobe(1'b1, 8'h6F, 8'h0F);
    strobe(1'b1, 8'hA0, 8'hAA);
    chk("tx3", 16'h20AA, txp[2]);
    rd(4'h3, 8'h0E, 8'h20);
    rd(4'h2, 8'h0E, 8'h20);
    strobe(1'b1, 8'hA0, 8'hFF);
    rd(4'h2, 8'h0E, 8'hB7);
    strobe(1'b1, 8'h6E, 8'h42);
    strobe(1'b1, 8'hA0, 8'h00);
    rdx(8'hA0, 8'h00);
    rd(4'h2, 8'h0E, 8'hB7);
    rdx(8'h55, 8'h00);
    pulse(1'b0);
    rd(4'h1, 8'h0E, 8'h28);
    pulse(1'b1);
    chk("toggle", 16'h0, {15'h0, txp[0].toggle});
    u_lp0.send(16'hA123, 3, 0, 1'b0);
    wait_acc(1'b1);
    rd(4'h1, 8'h10, 8'hE9);
    rd(4'h1, 8'h11, 8'h23);
    u_lp0.send(16'h3456, 3, 1, 1'b1);
    wait_acc(1'b0);
    u_lp0.send(16'h1000, 3, 2, 1'b0);
    wait_acc(1'b1);
    rd(4'h1, 8'h10, 8'h50);
    end_of_test();
  end
endmodule : anpr_regs_tb
bind anpr_regs anpr_regs_checker u_chk (.clk(clk), .reset_n(reset_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .flp_in(flp_in), .np_start(np_start),
  .local_base_toggle(local_base_toggle),
  .partner_base_toggle(partner_base_toggle), .tx_page_done(tx_page_done),
  .tx_next_page(tx_next_page), .rx_page_accepted(rx_page_accepted));
